/* design/two_zone_temp_supervisor_core.sv */
/*
  Two-zone temperature supervisor core: conversion sequencer, threshold
  registers, fault queues, alarm and critical outputs, shutdown handling.
  Assumes a serial protocol engine outside that raises bus_active_i during an
  access and drives the register port; converter results arrive on the
  system clock when the sequencer ends a conversion.
*/
// Local design decisions: the plain strobed port and the address map.
`timescale 1ns/1ps
module two_zone_temp_supervisor_core #(
  parameter int LOCAL_CONV_CYCLES = temp_supervisor_pkg::LOCAL_CONV_CYCLES_DFLT
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic bus_active_i,
  input wire logic address_select_pin_i,
  input wire logic remote_sensor_fault_i,
  input wire logic [7:0] local_adc_i,
  input wire logic [7:0] remote_adc_i,
  output logic alarm_out_n_o,
  output logic critical_out_n_o,
  output logic address_select_o
);
  import temp_supervisor_pkg::*;

  localparam int REMOTE_CONV_CYCLES = REMOTE_CONV_FACTOR * LOCAL_CONV_CYCLES;
  localparam int CNT_W = $clog2(REMOTE_CONV_CYCLES + 1);
  localparam logic [CNT_W-1:0] LOCAL_LAST = CNT_W'(LOCAL_CONV_CYCLES - 1);
  localparam logic [CNT_W-1:0] REMOTE_LAST = CNT_W'(REMOTE_CONV_CYCLES - 1);

  typedef struct packed {
    logic bus_meta;
    logic bus_sync;
    logic fault_meta;
    logic fault_sync;
    logic addr_meta;
    logic addr_sync;
    logic [1:0] addr_age;
    logic addr_taken;
    logic address_select;
    conv_state_e conv_state;
    logic [CNT_W-1:0] conv_cnt;
    logic redo_local;
    logic [1:0] done;
    logic [1:0][7:0] temp;
    logic [1:0][7:0] setpoint;
    logic [1:0][7:0] hysteresis;
    logic [7:0] critical_out_n_set;
    logic [7:0] critical_out_n_release;
    logic shutdown;
    logic mode;
    logic mask;
    logic [1:0] queue_code;
    logic [1:0] status;
    logic [1:0] armed_high;
    logic [1:0] zone_state;
    logic alarm_pend;
    logic critical_out_n_state;
    logic [7:0] rdata;
    logic alarm_n;
    logic critical_out_n_n;
  } core_s;

  core_s cur;
  core_s next_cur;

  logic [1:0] hit_high;
  logic [1:0] hit_low;
  logic critical_out_n_hit_high;
  logic critical_out_n_hit_low;

  for (genvar z = 0; z < 2; z++) begin : g_zone
    queue_filter u_zone_filter (
      .sys_clk_i(sys_clk_i),
      .rst_i(rst_i),
      .sample_i(cur.done[z]),
      .above_i($signed(cur.temp[z]) > $signed(cur.setpoint[z])),
      .below_i($signed(cur.temp[z]) < $signed(cur.hysteresis[z])),
      .depth_code_i(cur.queue_code),
      .hit_above_o(hit_high[z]),
      .hit_below_o(hit_low[z])
    );
  end

  queue_filter u_critical_out_n_filter (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .sample_i(cur.done[ZONE_REMOTE]),
    .above_i($signed(cur.temp[ZONE_REMOTE]) > $signed(cur.critical_out_n_set)),
    .below_i($signed(cur.temp[ZONE_REMOTE]) < $signed(cur.critical_out_n_release)),
    .depth_code_i(cur.queue_code),
    .hit_above_o(critical_out_n_hit_high),
    .hit_below_o(critical_out_n_hit_low)
  );

  always_comb begin
    logic busy;
    logic enter_shutdown;
    logic any_read;
    logic cfg_read;
    logic [1:0] zone_set;
    logic pend_set;
    busy = 1'b0;
    enter_shutdown = 1'b0;
    any_read = 1'b0;
    cfg_read = 1'b0;
    zone_set = 2'h0;
    pend_set = 1'b0;
    next_cur = cur;

    // Pin synchronisers
    next_cur.bus_meta = bus_active_i;
    next_cur.bus_sync = cur.bus_meta;
    next_cur.fault_meta = remote_sensor_fault_i;
    next_cur.fault_sync = cur.fault_meta;
    next_cur.addr_meta = address_select_pin_i;
    next_cur.addr_sync = cur.addr_meta;

    // Address pin is caught once, after the synchroniser has filled
    if (cur.addr_age != ADDR_SETTLE) begin
      next_cur.addr_age = 2'(cur.addr_age + 2'h1);
    end else if (!cur.addr_taken) begin
      next_cur.addr_taken = 1'b1;
      next_cur.address_select = cur.addr_sync;
    end

    // Register access, available in any power state
    any_read = reg_rd_i;
    cfg_read = reg_rd_i && (reg_addr_i == ADDR_CONFIG);
    busy = cur.bus_sync || reg_wr_i || reg_rd_i;
    if (reg_rd_i) begin
      case (reg_addr_i)
        ADDR_LOCAL_TEMP: next_cur.rdata = cur.temp[ZONE_LOCAL];
        ADDR_CONFIG: next_cur.rdata = {cur.critical_out_n_state, cur.status[ZONE_REMOTE], cur.status[ZONE_LOCAL],
                                       cur.queue_code, cur.mask, cur.mode, cur.shutdown};
        ADDR_LOCAL_HYST: next_cur.rdata = cur.hysteresis[ZONE_LOCAL];
        ADDR_LOCAL_SET: next_cur.rdata = cur.setpoint[ZONE_LOCAL];
        ADDR_REMOTE_TEMP: next_cur.rdata = cur.temp[ZONE_REMOTE];
        ADDR_REMOTE_HYST: next_cur.rdata = cur.hysteresis[ZONE_REMOTE];
        ADDR_REMOTE_SET: next_cur.rdata = cur.setpoint[ZONE_REMOTE];
        ADDR_CRITICAL_OUT_N_RELEASE: next_cur.rdata = cur.critical_out_n_release;
        ADDR_CRITICAL_OUT_N_SET: next_cur.rdata = cur.critical_out_n_set;
        default: next_cur.rdata = 8'h00;
      endcase
    end
    if (reg_wr_i) begin
      case (reg_addr_i)
        ADDR_CONFIG: begin
          enter_shutdown = reg_wdata_i[CFG_SHUTDOWN] && !cur.shutdown;
          next_cur.shutdown = reg_wdata_i[CFG_SHUTDOWN];
          next_cur.mode = reg_wdata_i[CFG_MODE];
          next_cur.mask = reg_wdata_i[CFG_MASK];
          next_cur.queue_code = reg_wdata_i[CFG_QUEUE_HI:CFG_QUEUE_LO];
        end
        ADDR_LOCAL_HYST: next_cur.hysteresis[ZONE_LOCAL] = reg_wdata_i;
        ADDR_LOCAL_SET: next_cur.setpoint[ZONE_LOCAL] = reg_wdata_i;
        ADDR_REMOTE_TEMP: next_cur.temp[ZONE_REMOTE] = reg_wdata_i;
        ADDR_REMOTE_HYST: next_cur.hysteresis[ZONE_REMOTE] = reg_wdata_i;
        ADDR_REMOTE_SET: next_cur.setpoint[ZONE_REMOTE] = reg_wdata_i;
        ADDR_CRITICAL_OUT_N_RELEASE: next_cur.critical_out_n_release = reg_wdata_i;
        ADDR_CRITICAL_OUT_N_SET: next_cur.critical_out_n_set = reg_wdata_i;
        default: ;
      endcase
    end

    // Conversion sequencer
    next_cur.done = 2'h0;
    case (cur.conv_state)
      CONV_IDLE: begin
        next_cur.conv_cnt = '0;
        if (cur.shutdown) begin
          next_cur.redo_local = 1'b0;
        end else if (!busy) begin
          next_cur.conv_state = cur.redo_local ? CONV_LOCAL : CONV_REMOTE;
        end
      end
      CONV_REMOTE: begin
        if (cur.shutdown || busy) begin
          next_cur.conv_state = CONV_IDLE;
          next_cur.redo_local = 1'b0;
        end else if (cur.conv_cnt == REMOTE_LAST) begin
          next_cur.conv_cnt = '0;
          next_cur.conv_state = CONV_LOCAL;
          next_cur.temp[ZONE_REMOTE] = cur.fault_sync ? TEMP_FAULT_VALUE : remote_adc_i;
          next_cur.done[ZONE_REMOTE] = 1'b1;
        end else begin
          next_cur.conv_cnt = CNT_W'(cur.conv_cnt + 1'b1);
        end
      end
      CONV_LOCAL: begin
        if (cur.shutdown || busy) begin
          next_cur.conv_state = CONV_IDLE;
          next_cur.redo_local = !cur.shutdown;
        end else if (cur.conv_cnt == LOCAL_LAST) begin
          next_cur.conv_cnt = '0;
          next_cur.conv_state = CONV_REMOTE;
          next_cur.redo_local = 1'b0;
          next_cur.temp[ZONE_LOCAL] = local_adc_i;
          next_cur.done[ZONE_LOCAL] = 1'b1;
        end else begin
          next_cur.conv_cnt = CNT_W'(cur.conv_cnt + 1'b1);
        end
      end
      default: next_cur.conv_state = CONV_IDLE;
    endcase

    // Zone events; filters only pulse after a completed conversion
    for (int z = 0; z < 2; z++) begin
      if (hit_high[z]) begin
        next_cur.zone_state[z] = 1'b1;
      end else if (hit_low[z]) begin
        next_cur.zone_state[z] = 1'b0;
      end
      if (cur.armed_high[z] && hit_high[z]) begin
        zone_set[z] = 1'b1;
        next_cur.armed_high[z] = 1'b0;
      end else if (!cur.armed_high[z] && hit_low[z]) begin
        zone_set[z] = 1'b1;
        next_cur.armed_high[z] = 1'b1;
      end
    end

    if (!cur.mode) begin
      next_cur.status = next_cur.zone_state;
      next_cur.alarm_pend = 1'b0;
    end else begin
      pend_set = |zone_set;
      if (cfg_read || enter_shutdown) begin
        next_cur.status = 2'h0;
      end
      if (any_read || enter_shutdown) begin
        next_cur.alarm_pend = 1'b0;
      end
      // Event wins over a clear in the same cycle
      next_cur.status = next_cur.status | zone_set;
      next_cur.alarm_pend = next_cur.alarm_pend | pend_set;
    end

    // Critical comparison ignores mode, mask and shutdown entry
    if (critical_out_n_hit_high) begin
      next_cur.critical_out_n_state = 1'b1;
    end else if (critical_out_n_hit_low) begin
      next_cur.critical_out_n_state = 1'b0;
    end
    next_cur.critical_out_n_n = !next_cur.critical_out_n_state;

    // Comparator alarm holds through shutdown since no events arrive then
    next_cur.alarm_n = !(!next_cur.mask && (next_cur.mode ? next_cur.alarm_pend : |next_cur.zone_state));
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur <= '0;
      cur.conv_state <= CONV_IDLE;
      cur.temp <= {RST_TEMP, RST_TEMP};
      cur.setpoint <= {RST_REMOTE_SET, RST_LOCAL_SET};
      cur.hysteresis <= {RST_REMOTE_HYST, RST_LOCAL_HYST};
      cur.critical_out_n_set <= RST_CRITICAL_OUT_N_SET;
      cur.critical_out_n_release <= RST_CRITICAL_OUT_N_RELEASE;
      cur.queue_code <= RST_QUEUE_CODE;
      cur.armed_high <= 2'h3;
      cur.alarm_n <= 1'b1;
      cur.critical_out_n_n <= 1'b1;
    end else begin
      cur <= next_cur;
    end
  end

  assign reg_rdata_o = cur.rdata;
  assign alarm_out_n_o = cur.alarm_n;
  assign critical_out_n_o = cur.critical_out_n_n;
  assign address_select_o = cur.address_select;

endmodule

/* design/temp_supervisor_pkg.sv */
/*
  Constants, register map, config field layout and reset values shared by the
  two-zone temperature supervisor core and its fault queue filter.
  Assumes a 100 MHz system clock and a byte-wide register port.
*/
package temp_supervisor_pkg;

  localparam logic [7:0] ADDR_LOCAL_TEMP = 8'h00;
  localparam logic [7:0] ADDR_CONFIG = 8'h01;
  localparam logic [7:0] ADDR_LOCAL_HYST = 8'h02;
  localparam logic [7:0] ADDR_LOCAL_SET = 8'h03;
  localparam logic [7:0] ADDR_REMOTE_TEMP = 8'h10;
  localparam logic [7:0] ADDR_REMOTE_HYST = 8'h12;
  localparam logic [7:0] ADDR_REMOTE_SET = 8'h13;
  localparam logic [7:0] ADDR_CRITICAL_OUT_N_RELEASE = 8'h22;
  localparam logic [7:0] ADDR_CRITICAL_OUT_N_SET = 8'h23;

  localparam logic [7:0] RST_TEMP = 8'h00;
  localparam logic [7:0] RST_LOCAL_HYST = 8'h4C;
  localparam logic [7:0] RST_LOCAL_SET = 8'h51;
  localparam logic [7:0] RST_REMOTE_HYST = 8'h5C;
  localparam logic [7:0] RST_REMOTE_SET = 8'h61;
  localparam logic [7:0] RST_CRITICAL_OUT_N_RELEASE = 8'h5C;
  localparam logic [7:0] RST_CRITICAL_OUT_N_SET = 8'h61;
  localparam logic [1:0] RST_QUEUE_CODE = 2'h0;

  // Config register fields
  localparam int CFG_SHUTDOWN = 0;
  localparam int CFG_MODE = 1;
  localparam int CFG_MASK = 2;
  localparam int CFG_QUEUE_LO = 3;
  localparam int CFG_QUEUE_HI = 4;
  localparam int CFG_STATUS_LOCAL = 5;
  localparam int CFG_STATUS_REMOTE = 6;
  localparam int CFG_CRITICAL_OUT_N = 7;

  localparam int ZONE_LOCAL = 0;
  localparam int ZONE_REMOTE = 1;

  // Remote reading forced on a sensor fault, above any sane threshold
  localparam logic [7:0] TEMP_FAULT_VALUE = 8'h7F;

  localparam int CLK_PERIOD_NS = 10;
  localparam int LOCAL_CONV_US = 80;
  localparam int REMOTE_CONV_FACTOR = 2;
  localparam int LOCAL_CONV_CYCLES_DFLT = LOCAL_CONV_US * 1000 / CLK_PERIOD_NS;

  localparam logic [1:0] ADDR_SETTLE = 2'h2;
  localparam int QUEUE_W = 3;

  typedef enum logic [1:0] {
    CONV_IDLE,
    CONV_REMOTE,
    CONV_LOCAL
  } conv_state_e;

  function automatic logic [QUEUE_W-1:0] depth_of(input logic [1:0] code);
    case (code)
      2'h0: depth_of = 3'h1;
      2'h1: depth_of = 3'h2;
      2'h2: depth_of = 3'h4;
      default: depth_of = 3'h6;
    endcase
  endfunction

endpackage

/* design/queue_filter.sv */
/*
  Fault queue filter: counts consecutive conversions above and below two
  thresholds and pulses when a condition has held for the programmed depth.
  Assumes sample_i is a one-cycle pulse per completed conversion.
*/
`timescale 1ns/1ps
module queue_filter (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic sample_i,
  input wire logic above_i,
  input wire logic below_i,
  input wire logic [1:0] depth_code_i,
  output logic hit_above_o,
  output logic hit_below_o
);
  import temp_supervisor_pkg::*;

  typedef struct packed {
    logic [QUEUE_W-1:0] above_cnt;
    logic [QUEUE_W-1:0] below_cnt;
    logic hit_above;
    logic hit_below;
  } filt_s;

  filt_s cur;
  filt_s next_cur;

  always_comb begin
    logic [QUEUE_W-1:0] depth;
    depth = depth_of(depth_code_i);
    next_cur = cur;
    next_cur.hit_above = 1'b0;
    next_cur.hit_below = 1'b0;
    if (sample_i) begin
      // Any break in the run restarts the count
      next_cur.above_cnt = '0;
      next_cur.below_cnt = '0;
      if (above_i) begin
        next_cur.above_cnt = (cur.above_cnt >= depth) ? depth : QUEUE_W'(cur.above_cnt + 3'h1);
        next_cur.hit_above = (QUEUE_W'(cur.above_cnt + 3'h1) >= depth);
      end
      if (below_i) begin
        next_cur.below_cnt = (cur.below_cnt >= depth) ? depth : QUEUE_W'(cur.below_cnt + 3'h1);
        next_cur.hit_below = (QUEUE_W'(cur.below_cnt + 3'h1) >= depth);
      end
    end
  end

  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  assign hit_above_o = cur.hit_above;
  assign hit_below_o = cur.hit_below;

endmodule

/* dv/supervisor_chk.sv */
/* Port-level properties of the supervisor core, bound to every core instance.
   Assumes config writes arrive on the register port; mode, mask, shutdown are mirrored. */
`timescale 1ns/1ps
module supervisor_chk #(
  parameter int LOCAL_CONV_CYCLES = 20
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic bus_active_i,
  input wire logic alarm_out_n_o,
  input wire logic critical_out_n_o,
  input wire logic address_select_o
);
  import temp_supervisor_pkg::*;
  logic shut, mode, mask;
  logic [15:0] quiet, quiet_rd;
  logic [2:0] since_rst;
  // Cycles without any access, and without reads or bus activity
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      {mask, mode, shut} <= 3'h0;
      quiet <= 16'h0;
      quiet_rd <= 16'h0;
      since_rst <= 3'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == ADDR_CONFIG) begin
        {mask, mode, shut} <= reg_wdata_i[2:0];
      end
      quiet <= (reg_wr_i || reg_rd_i || bus_active_i) ? 16'h0 : quiet + {15'h0, quiet != 16'hFFFF};
      quiet_rd <= (reg_rd_i || bus_active_i) ? 16'h0 : quiet_rd + {15'h0, quiet_rd != 16'hFFFF};
      since_rst <= since_rst + {2'h0, since_rst != 3'h7};
    end
  end
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  AST_RESET_IDLE: assert property ($past(rst_i) |-> alarm_out_n_o && critical_out_n_o)
    else $error("outputs active right after reset");
  AST_STRAP_HELD: assert property (since_rst == 3'h7 |-> $stable(address_select_o))
    else $error("address strap changed after capture");
  AST_SHUTDOWN_BIT_QUIET: assert property (shut && {shut, mask, mode} == $past({shut, mask, mode}, 3)
    |-> $stable(alarm_out_n_o) && $stable(critical_out_n_o))
    else $error("output changed during shutdown");
  AST_INT_SHUTDOWN_BIT_CLEAR: assert property (reg_wr_i && reg_addr_i == ADDR_CONFIG && reg_wdata_i[1:0] == 2'h3
    |-> ##[1:3] alarm_out_n_o)
    else $error("alarm kept on shutdown in interrupt mode");
  AST_INT_READ_RELEASE: assert property (mode && !shut && reg_rd_i |-> ##[1:2] alarm_out_n_o)
    else $error("alarm not released by read");
  AST_MASK_HIDES: assert property (mask && $past(mask, 3) |-> alarm_out_n_o)
    else $error("masked alarm asserted");
  AST_ALARM_NEEDS_CONV: assert property ($fell(alarm_out_n_o)
    |-> quiet_rd > LOCAL_CONV_CYCLES || quiet < 16'h4)
    else $error("alarm asserted without a finished conversion");
  AST_CRITICAL_OUT_N_NEEDS_CONV: assert property ($fell(critical_out_n_o) |-> quiet > LOCAL_CONV_CYCLES)
    else $error("critical asserted without a finished conversion");
  AST_RDATA_HOLD: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
    else $error("read data changed without a read");
  cover property ($fell(alarm_out_n_o));
  cover property ($fell(critical_out_n_o));
  cover property (mode && reg_rd_i);
endmodule
bind two_zone_temp_supervisor_core supervisor_chk #(.LOCAL_CONV_CYCLES(LOCAL_CONV_CYCLES)) supervisor_chk_i (
  .sys_clk_i, .rst_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
  .bus_active_i, .alarm_out_n_o, .critical_out_n_o, .address_select_o);

/* dv/host_model.sv */
/* Host controller model: register port cycles and bus-activity line.
   Assumes calls from the bench; expected read data is queued as {addr, data}. */
`timescale 1ns/1ps
module host_model (
  input wire logic sys_clk_i,
  output logic [7:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  output logic busy_o
);
  logic [15:0] exp_q[$];
  initial begin
    addr_o = 8'h00;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
    busy_o = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge sys_clk_i);
    wr_o <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk_i);
    exp_q.push_back({a, e});
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge sys_clk_i);
    rd_o <= 1'b0;
  endtask
  task automatic hold_bus(input int n);
    @(posedge sys_clk_i);
    busy_o <= 1'b1;
    repeat (n) @(posedge sys_clk_i);
    busy_o <= 1'b0;
  endtask
endmodule

/* dv/two_zone_temp_supervisor_core_tb.sv */
/* Self-checking bench for the supervisor core with a host model.
   Converter results, sensor fault and address strap are driven here. */
`timescale 1ns/1ps
module two_zone_temp_supervisor_core_tb;
  import temp_supervisor_pkg::*;
  localparam int N = 20;
  logic sys_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr, wdata, rdata, loc, rem;
  logic wr, rd, busy, strap, fault, alarm_n, critical_out_n_n, strap_o;
  logic rd_d = 1'b0;
  logic [15:0] note;
  logic [15:0] rst_tab[8] = '{16'h0100, 16'h024C, 16'h0351, 16'h125C, 16'h1361, 16'h225C, 16'h2361, 16'h0500};
  int dep[4] = '{1, 2, 4, 6};
  int fails = 0;
  int n_compared = 0;
  int cyc = 0;
  always #5 sys_clk_i = ~sys_clk_i;
  host_model host_model_i (.sys_clk_i, .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd), .busy_o(busy));
  two_zone_temp_supervisor_core #(.LOCAL_CONV_CYCLES(N)) two_zone_temp_supervisor_core_i (
    .sys_clk_i, .rst_i, .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_rdata_o(rdata), .bus_active_i(busy), .address_select_pin_i(strap), .remote_sensor_fault_i(fault),
    .local_adc_i(loc), .remote_adc_i(rem), .alarm_out_n_o(alarm_n), .critical_out_n_o(critical_out_n_n),
    .address_select_o(strap_o));
  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    n_compared++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_pins(input logic a, input logic c);
    n_compared++;
    if ({alarm_n, critical_out_n_n} !== {a, c}) begin
      fails++;
      $display("BAD pins expected %b seen %b", {a, c}, {alarm_n, critical_out_n_n});
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge sys_clk_i);
    #1;
  endtask
  task automatic done(input string name);
    $display("test %s finished", name);
  endtask
  task automatic wrap_up;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  always @(posedge sys_clk_i) begin
    rd_d <= rd;
    cyc++;
    if (cyc == 20000) begin
      fails++;
      wrap_up;
    end
  end
  // Read data appears in the cycle after the strobe and holds until the next read
  always @(negedge sys_clk_i) begin
    if (rd_d === 1'b1) begin
      note = host_model_i.exp_q.pop_front();
      chk($sformatf("reg %h", note[15:8]), note[7:0], rdata);
    end
  end
  initial begin
    void'($urandom(32'h2343D1A0));
    {strap, loc} = {1'b1, 8'($urandom())};
    loc[7] = 1'b1;
    rem = 8'h10;
    fault = 1'b0;
    w(2);
    rst_i <= 1'b0;
    foreach (rst_tab[i]) host_model_i.rd(rst_tab[i][15:8], rst_tab[i][7:0]);
    w(2);
    chk_pins(1'b1, 1'b1);
    chk("strap", {7'h0, strap}, {7'h0, strap_o});
    done("reset");
    w(50);
    host_model_i.rd(ADDR_LOCAL_TEMP, RST_TEMP);
    host_model_i.rd(ADDR_REMOTE_TEMP, 8'h10);
    w(90);
    host_model_i.rd(ADDR_LOCAL_TEMP, loc);
    done("sequence");
    rem <= 8'h33;
    repeat (12) begin
      host_model_i.hold_bus(3);
      w(27);
    end
    host_model_i.rd(ADDR_REMOTE_TEMP, 8'h10);
    w(150);
    host_model_i.rd(ADDR_REMOTE_TEMP, 8'h33);
    done("abort");
    for (int c = 0; c < 4; c++) begin
      rem <= 8'h10;
      w(450);
      // A short shutdown drops any pending local redo so the run restarts at remote
      host_model_i.wr(ADDR_CONFIG, 8'h01);
      host_model_i.wr(ADDR_CONFIG, {3'h0, 2'(c), 3'h0});
      rem <= 8'h62;
      w(43 + (dep[c] - 1) * 61 - 15);
      chk_pins(1'b1, 1'b1);
      w(30);
      chk_pins(1'b0, 1'b0);
      host_model_i.rd(ADDR_CONFIG, {2'h3, 1'b0, 2'(c), 3'h0});
    end
    done("depth");
    host_model_i.wr(ADDR_CONFIG, 8'h01);
    rem <= 8'h10;
    fault <= 1'b1;
    w(300);
    chk_pins(1'b0, 1'b0);
    host_model_i.rd(ADDR_REMOTE_TEMP, 8'h62);
    host_model_i.wr(ADDR_LOCAL_SET, 8'h55);
    host_model_i.rd(ADDR_LOCAL_SET, 8'h55);
    host_model_i.wr(ADDR_LOCAL_SET, RST_LOCAL_SET);
    host_model_i.wr(ADDR_CONFIG, 8'h00);
    w(60);
    host_model_i.rd(ADDR_REMOTE_TEMP, TEMP_FAULT_VALUE);
    fault <= 1'b0;
    w(150);
    chk_pins(1'b1, 1'b1);
    done("shutdown");
    host_model_i.wr(ADDR_CONFIG, 8'h04);
    rem <= 8'h62;
    w(100);
    chk_pins(1'b1, 1'b0);
    host_model_i.rd(ADDR_CONFIG, 8'hC4);
    rem <= 8'h10;
    w(100);
    done("mask");
    host_model_i.wr(ADDR_CONFIG, 8'h02);
    rem <= 8'h62;
    w(80);
    chk_pins(1'b0, 1'b0);
    host_model_i.rd(ADDR_REMOTE_TEMP, 8'h62);
    w(2);
    chk_pins(1'b1, 1'b0);
    w(150);
    chk_pins(1'b1, 1'b0);
    host_model_i.rd(ADDR_CONFIG, 8'hC2);
    host_model_i.rd(ADDR_CONFIG, 8'h82);
    rem <= 8'h10;
    w(100);
    chk_pins(1'b0, 1'b1);
    host_model_i.wr(ADDR_CONFIG, 8'h03);
    w(3);
    chk_pins(1'b1, 1'b1);
    host_model_i.rd(ADDR_CONFIG, 8'h03);
    w(2);
    done("interrupt");
    wrap_up;
  end
endmodule
